/* src/sbt_pkg.sv */
// shared constants and types for the boundary scan test access port
// assumes one tap instance per device, link on the tap clock
package sbt_pkg;

    // instruction register
    localparam int          IR_W          = 3;
    localparam logic [2:0]  INS_EXTEST    = 3'h0;
    localparam logic [2:0]  INS_IDCODE    = 3'h1;
    localparam logic [2:0]  INS_SAMPLEZ   = 3'h2;
    localparam logic [2:0]  INS_PRELOAD   = 3'h4;
    localparam logic [2:0]  INS_BYPASS    = 3'h7;
    localparam logic [2:0]  IR_CAPTURE    = 3'h1;

    // boundary chain: cells 0..107 follow balls, cell 108 gates q bus
    localparam int          BSR_LEN       = 109;
    localparam int          BALLS         = 108;
    localparam int          CELL_OE       = 108;

    // identification word pieces
    localparam int          ID_W          = 32;
    localparam logic [2:0]  ID_REVISION   = 3'h0;
    localparam logic [10:0] ID_MAKER      = 11'h2a5; // arbitrary value
    localparam logic        ID_START      = 1'h1;
    localparam logic [2:0]  DENSITY_18M   = 3'h1;
    localparam logic [2:0]  DENSITY_36M   = 3'h2;
    localparam logic [2:0]  DENSITY_72M   = 3'h3;
    localparam logic [1:0]  WIDTH_X36     = 2'h3;
    localparam logic [1:0]  WIDTH_X18     = 2'h2;
    localparam logic [2:0]  CFG_DENSITY   = DENSITY_72M;
    localparam logic [1:0]  CFG_WIDTH     = WIDTH_X36;
    localparam logic        CFG_ENH_GEN   = 1'h0; // base generation
    localparam logic        CFG_SEP_PORT  = 1'h0; // common-port ddr
    localparam logic        CFG_RL25      = 1'h0;
    localparam logic        CFG_BURST4    = 1'h0; // burst of two
    localparam logic        CFG_SEP_IO    = 1'h0; // shared data bus
    localparam logic        CFG_ODT       = 1'h0;
    localparam logic [1:0]  CFG_FIXED01   = 2'h1;
    localparam logic        CFG_ZERO      = 1'h0;
    localparam logic [16:0] ID_CONFIG     = {CFG_ZERO, CFG_ODT, CFG_DENSITY,
                                             CFG_ZERO, CFG_WIDTH,
                                             CFG_FIXED01, CFG_ENH_GEN,
                                             CFG_SEP_PORT, CFG_RL25,
                                             CFG_BURST4, CFG_ODT,
                                             CFG_SEP_IO, CFG_ZERO};
    localparam logic [31:0] ID_WORD       = {ID_REVISION, ID_CONFIG,
                                             ID_MAKER, ID_START};

    // buffering of applied words
    localparam int          UPD_DEPTH     = 32;

    // tap controller states
    typedef enum logic [3:0] {
        ST_RESET, ST_IDLE, ST_SEL_DR, ST_CAP_DR, ST_SH_DR, ST_EX1_DR,
        ST_PA_DR, ST_EX2_DR, ST_UPD_DR, ST_SEL_IR, ST_CAP_IR, ST_SH_IR,
        ST_EX1_IR, ST_PA_IR, ST_EX2_IR, ST_UPD_IR
    } sbt_state_e;

    // word handed from the tap to the pin side
    typedef struct packed {
        logic [IR_W-1:0]    instr;
        logic [BSR_LEN-1:0] cells;
    } sbt_upd_s;

endpackage

/* src/sbt_sync.sv */
// two flip-flop level synchroniser, one bit per lane
// assumes each lane is a slow level; no word coherency across lanes
module sbt_sync #(
    parameter int W = 1
) (
    // clock and reset
    input  wire logic         i_clk,
    input  wire logic         i_arst_n,
    // levels
    input  wire logic [W-1:0] i_d,
    output logic      [W-1:0] o_q
);
    logic [W-1:0] meta_q;
    logic [W-1:0] sync_q;

    // first stage feeds only the second
    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            meta_q <= '0;
            sync_q <= '0;
        end else begin
            meta_q <= i_d;
            sync_q <= meta_q;
        end
    end

    assign o_q = sync_q;
endmodule

/* src/sbt_fifo.sv */
// flip-flop fifo with valid/ready on both sides
// assumes a single clock; full and empty are exact
module sbt_fifo #(
    parameter int W = 8,
    parameter int D = 4
) (
    // clock and reset
    input  wire logic         i_clk,
    input  wire logic         i_arst_n,
    // fill side
    input  wire logic         i_in_valid,
    output logic              o_in_ready,
    input  wire logic [W-1:0] i_in_data,
    // drain side
    output logic              o_out_valid,
    input  wire logic         i_out_ready,
    output logic      [W-1:0] o_out_data
);
    localparam int AW = $clog2(D);
    logic [W-1:0] mem_q [D];
    logic [AW-1:0] wr_q;
    logic [AW-1:0] rd_q;
    logic [AW:0]   cnt_q;
    wire           push = i_in_valid && o_in_ready;
    wire           pop  = o_out_valid && i_out_ready;

    // pointers, storage and fill count
    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            wr_q  <= '0;
            rd_q  <= '0;
            cnt_q <= '0;
        end else begin
            if (push) begin
                mem_q[wr_q] <= i_in_data;
                wr_q        <= (wr_q == AW'(D - 1)) ? '0 : wr_q + 1'b1;
            end
            if (pop) begin
                rd_q <= (rd_q == AW'(D - 1)) ? '0 : rd_q + 1'b1;
            end
            cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
        end
    end

    assign o_in_ready  = cnt_q != (AW+1)'(D);
    assign o_out_valid = cnt_q != '0;
    assign o_out_data  = mem_q[rd_q];
endmodule

/* src/sbt_tap.sv */
// boundary scan test access port: instruction decode, data registers,
// and the hand-over of updated cells to the pin side
// assumes i_tck is the controller's clock and i_mclk the pin-side clock
//
// Functional notes
// - codes 000, 010, 100 put the boundary chain between tdi and tdo
// - code 001 selects 32-bit identification, code 111 the bypass cell
// - identification bit 0 is one, bits 11..1 hold the maker code
// - bits 31..29 revision, bits 28..12 part configuration
// - density subfield: 001 18Mb, 010 36Mb, 011 72Mb
// - width subfield: 11 for x36, 10 for x18
// - read latency 2.5 flag and burst-of-four flag
// - separate io flag and on-die termination flag
// - chain of 109 cells, 108 ball cells then one internal
// - cell 108 changes only by shift, update and reset-state clear, never from a ball
// - instruction defaults to identification at power-up and reset state
// - chain msb next to tdi, lsb next to tdo
// - under external test latched cell 108 enables or floats outputs
// - sample-z floats the data outputs until the next instruction update
module sbt_tap
    import sbt_pkg::*;
(
    // clocks and reset
    input  wire logic                    i_mclk,
    input  wire logic                    i_arst_n,
    input  wire logic                    i_tck,
    // serial test link
    input  wire logic                    i_tms,
    input  wire logic                    i_tdi,
    output logic                         o_tdo,
    output logic                         o_tdo_oe,
    // ball levels seen by the chain, pin-side domain
    input  wire logic [sbt_pkg::BALLS-1:0] i_ball,
    // applied pin control, pin-side domain
    input  wire logic                    i_drv_ready,
    output logic                         o_ext_mode,
    output logic [sbt_pkg::BALLS-1:0]    o_ball_drive,
    output logic                         o_q_oe,
    output logic                         o_upd_stall
);
    import sbt_pkg::*;

    sbt_state_e          st_q;
    sbt_state_e          st_d;
    logic [IR_W-1:0]     ir_sr_q;
    logic [IR_W-1:0]     ir_q;
    logic [ID_W-1:0]     id_sr_q;
    logic                byp_q;
    logic [BSR_LEN-1:0]  bsr_q;
    logic [BSR_LEN-1:0]  upd_q;
    logic                tog_q;
    logic                tdo_q;
    logic                tdo_oe_q;
    logic [BALLS-1:0]    ball_s;

    // instruction decode
    wire sel_bsr = (ir_q == INS_EXTEST) || (ir_q == INS_SAMPLEZ) ||
                   (ir_q == INS_PRELOAD);
    wire sel_id  = (ir_q == INS_IDCODE);
    wire sel_byp = !sel_bsr && !sel_id;
    wire in_reset = (st_q == ST_RESET);
    wire cap_dr   = (st_q == ST_CAP_DR);
    wire sh_dr    = (st_q == ST_SH_DR);
    wire upd_dr   = (st_q == ST_UPD_DR);
    wire cap_ir   = (st_q == ST_CAP_IR);
    wire sh_ir    = (st_q == ST_SH_IR);
    wire upd_ir   = (st_q == ST_UPD_IR);

    // serial output selection
    wire dr_out = sel_bsr ? bsr_q[0] : sel_id ? id_sr_q[0] : byp_q;
    wire so_nxt = sh_ir ? ir_sr_q[0] : dr_out;

    // ball levels cross into the tap domain
    sbt_sync #(.W(BALLS)) u_ball_sync (
        .i_clk    (i_tck),
        .i_arst_n (i_arst_n),
        .i_d      (i_ball),
        .o_q      (ball_s)
    );

    // controller next state from tms
    always_comb begin
        st_d = st_q;
        unique case (st_q)
            ST_RESET:  st_d = i_tms ? ST_RESET  : ST_IDLE;
            ST_IDLE:   st_d = i_tms ? ST_SEL_DR : ST_IDLE;
            ST_SEL_DR: st_d = i_tms ? ST_SEL_IR : ST_CAP_DR;
            ST_CAP_DR: st_d = i_tms ? ST_EX1_DR : ST_SH_DR;
            ST_SH_DR:  st_d = i_tms ? ST_EX1_DR : ST_SH_DR;
            ST_EX1_DR: st_d = i_tms ? ST_UPD_DR : ST_PA_DR;
            ST_PA_DR:  st_d = i_tms ? ST_EX2_DR : ST_PA_DR;
            ST_EX2_DR: st_d = i_tms ? ST_UPD_DR : ST_SH_DR;
            ST_UPD_DR: st_d = i_tms ? ST_SEL_DR : ST_IDLE;
            ST_SEL_IR: st_d = i_tms ? ST_RESET  : ST_CAP_IR;
            ST_CAP_IR: st_d = i_tms ? ST_EX1_IR : ST_SH_IR;
            ST_SH_IR:  st_d = i_tms ? ST_EX1_IR : ST_SH_IR;
            ST_EX1_IR: st_d = i_tms ? ST_UPD_IR : ST_PA_IR;
            ST_PA_IR:  st_d = i_tms ? ST_EX2_IR : ST_PA_IR;
            ST_EX2_IR: st_d = i_tms ? ST_UPD_IR : ST_SH_IR;
            ST_UPD_IR: st_d = i_tms ? ST_SEL_DR : ST_IDLE;
        endcase
    end

    // controller state
    always_ff @(posedge i_tck or negedge i_arst_n) begin
        if (!i_arst_n) begin
            st_q <= ST_RESET;
        end else begin
            st_q <= st_d;
        end
    end

    // instruction shift and update, identification on reset
    always_ff @(posedge i_tck or negedge i_arst_n) begin
        if (!i_arst_n) begin
            ir_sr_q <= IR_CAPTURE;
            ir_q    <= INS_IDCODE;
        end else begin
            if (cap_ir) begin
                ir_sr_q <= IR_CAPTURE;
            end else if (sh_ir) begin
                ir_sr_q <= {i_tdi, ir_sr_q[IR_W-1:1]};
            end
            if (in_reset) begin
                ir_q <= INS_IDCODE;
            end else if (upd_ir) begin
                ir_q <= ir_sr_q;
            end
        end
    end

    // identification and bypass registers
    always_ff @(posedge i_tck or negedge i_arst_n) begin
        if (!i_arst_n) begin
            id_sr_q <= '0;
            byp_q   <= 1'b0;
        end else begin
            if (cap_dr && sel_id) begin
                id_sr_q <= ID_WORD;
            end else if (sh_dr && sel_id) begin
                id_sr_q <= {i_tdi, id_sr_q[ID_W-1:1]};
            end
            if (cap_dr && sel_byp) begin
                byp_q <= 1'b0;
            end else if (sh_dr && sel_byp) begin
                byp_q <= i_tdi;
            end
        end
    end

    // boundary chain: balls load cells 0..107, cell 108 keeps its bit
    always_ff @(posedge i_tck or negedge i_arst_n) begin
        if (!i_arst_n) begin
            bsr_q <= '0;
        end else if (cap_dr && sel_bsr) begin
            bsr_q[BALLS-1:0] <= ball_s;
        end else if (sh_dr && sel_bsr) begin
            bsr_q <= {i_tdi, bsr_q[BSR_LEN-1:1]};
        end
    end

    // update latches and hand-over toggle
    always_ff @(posedge i_tck or negedge i_arst_n) begin
        if (!i_arst_n) begin
            upd_q <= '0;
            tog_q <= 1'b0;
        end else begin
            if (in_reset) begin
                upd_q[CELL_OE] <= 1'b0;
            end else if (upd_dr && sel_bsr) begin
                upd_q <= bsr_q;
            end
            if ((upd_dr && sel_bsr) || upd_ir) begin
                tog_q <= !tog_q;
            end
        end
    end

    // serial output changes on the falling tap clock edge
    always_ff @(negedge i_tck or negedge i_arst_n) begin
        if (!i_arst_n) begin
            tdo_q    <= 1'b0;
            tdo_oe_q <= 1'b0;
        end else begin
            tdo_q    <= so_nxt;
            tdo_oe_q <= sh_dr || sh_ir;
        end
    end

    assign o_tdo    = tdo_q;
    assign o_tdo_oe = tdo_oe_q;

    // ---- pin-side domain ----
    logic     tog_s;
    logic     tog_seen_q;
    logic     pend_q;
    logic     in_ready;
    logic     out_valid;
    sbt_upd_s upd_word;
    sbt_upd_s out_word;
    sbt_upd_s app_q;

    // held tap words are stable while the toggle crosses
    assign upd_word.instr = ir_q;
    assign upd_word.cells = upd_q;

    sbt_sync #(.W(1)) u_tog_sync (
        .i_clk    (i_mclk),
        .i_arst_n (i_arst_n),
        .i_d      (tog_q),
        .o_q      (tog_s)
    );

    // one pending push per toggle; waits while the fifo is full
    always_ff @(posedge i_mclk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            tog_seen_q <= 1'b0;
            pend_q     <= 1'b0;
        end else begin
            tog_seen_q <= tog_s;
            pend_q     <= (tog_s != tog_seen_q) || (pend_q && !in_ready);
        end
    end

    sbt_fifo #(.W($bits(sbt_upd_s)), .D(UPD_DEPTH)) u_upd_fifo (
        .i_clk       (i_mclk),
        .i_arst_n    (i_arst_n),
        .i_in_valid  (pend_q),
        .o_in_ready  (in_ready),
        .i_in_data   (upd_word),
        .o_out_valid (out_valid),
        .i_out_ready (i_drv_ready),
        .o_out_data  (out_word)
    );

    // applied word drives the pins
    always_ff @(posedge i_mclk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            app_q.instr <= INS_IDCODE;
            app_q.cells <= '0;
        end else if (out_valid && i_drv_ready) begin
            app_q <= out_word;
        end
    end

    // output bus control per applied instruction
    wire app_ext = (app_q.instr == INS_EXTEST);
    wire app_sz  = (app_q.instr == INS_SAMPLEZ);
    assign o_ext_mode   = app_ext;
    assign o_ball_drive = app_q.cells[BALLS-1:0];
    assign o_q_oe       = app_ext ? app_q.cells[CELL_OE]
                        : !app_sz;
    assign o_upd_stall  = pend_q && !in_ready;

    // ---- checks ----
    sequence s_cap_id;
        cap_dr && sel_id;
    endsequence

    sequence s_cap_bsr;
        cap_dr && sel_bsr;
    endsequence

    sequence s_cap_byp;
        cap_dr && sel_byp;
    endsequence

    a_reset_idcode: assert property (
        @(posedge i_tck) disable iff (!i_arst_n)
        in_reset |=> (ir_q == INS_IDCODE))
        else $error("instruction not identification after reset state");

    a_id_capture: assert property (
        @(posedge i_tck) disable iff (!i_arst_n)
        s_cap_id |=> (id_sr_q[0] == 1'b1) && (id_sr_q[11:1] == ID_MAKER))
        else $error("identification start or maker field wrong");

    a_id_fields: assert property (
        @(posedge i_tck) disable iff (!i_arst_n)
        s_cap_id |=> (id_sr_q[31:29] == ID_REVISION) &&
                     (id_sr_q[28:12] == ID_CONFIG) &&
                     (id_sr_q[26:24] == CFG_DENSITY) &&
                     (id_sr_q[22:21] == CFG_WIDTH))
        else $error("identification configuration field wrong");

    a_id_lsb_first: assert property (
        @(posedge i_tck) disable iff (!i_arst_n)
        s_cap_id ##1 (sh_dr && sel_id) |=> (id_sr_q[ID_W-1] == $past(i_tdi))
            && (id_sr_q[0] == ID_WORD[1]))
        else $error("identification not shifted lsb first");

    a_bypass_path: assert property (
        @(posedge i_tck) disable iff (!i_arst_n)
        (sh_dr && (ir_q == INS_BYPASS)) |=> (byp_q == $past(i_tdi)))
        else $error("bypass cell did not take tdi");

    a_chain_shift: assert property (
        @(posedge i_tck) disable iff (!i_arst_n)
        (sh_dr && sel_bsr) |=> (bsr_q[BSR_LEN-1] == $past(i_tdi)) &&
            (bsr_q[BSR_LEN-2:0] == $past(bsr_q[BSR_LEN-1:1])))
        else $error("boundary chain shift wrong");

    a_cell_kept: assert property (
        @(posedge i_tck) disable iff (!i_arst_n)
        s_cap_bsr |=> (bsr_q[CELL_OE] == $past(bsr_q[CELL_OE])) &&
                      (bsr_q[BALLS-1:0] == $past(ball_s)))
        else $error("capture touched internal cell or missed balls");

    a_extest_oe: assert property (
        @(posedge i_mclk) disable iff (!i_arst_n)
        app_ext |-> (o_q_oe == app_q.cells[CELL_OE]))
        else $error("output enable not following internal cell");

    a_samplez_off: assert property (
        @(posedge i_mclk) disable iff (!i_arst_n)
        (app_sz && !(out_valid && i_drv_ready)) |=> !o_q_oe)
        else $error("outputs driven under sample-z");

    a_bypass_capture: assert property (
        @(posedge i_tck) disable iff (!i_arst_n)
        s_cap_byp |=> (byp_q == 1'b0))
        else $error("bypass cell not cleared at capture");

    a_chain_update: assert property (
        @(posedge i_tck) disable iff (!i_arst_n)
        (upd_dr && sel_bsr) |=> (upd_q == $past(bsr_q)))
        else $error("update latches did not take the chain");

    a_reset_cell: assert property (
        @(posedge i_tck) disable iff (!i_arst_n)
        in_reset |=> !upd_q[CELL_OE])
        else $error("output enable cell not cleared in reset state");

    a_id_first_out: assert property (
        @(posedge i_tck) disable iff (!i_arst_n)
        s_cap_id ##1 sh_dr |-> (o_tdo == ID_START))
        else $error("start marker not first on serial output");

    a_chain_tdo: assert property (
        @(posedge i_tck) disable iff (!i_arst_n)
        (sh_dr && sel_bsr) |-> (o_tdo == bsr_q[0]))
        else $error("serial output not the chain lsb");
endmodule

/* test/sbt_ctl_model.sv */
// board test controller model driving the tap's serial link
// assumes the tap samples tms/tdi on rising tck and moves tdo on falling tck
module sbt_ctl_model (
    // serial link toward the tap
    output logic      o_tck,
    output logic      o_tms,
    output logic      o_tdi,
    // answer from the tap
    input  wire logic i_tdo,
    input  wire logic i_tdo_oe
);
    timeunit 1ns;
    timeprecision 100ps;

    localparam int HALF = 80;

    logic last_oe;  // tdo enable seen at the last sample point
    logic shift_oe; // tdo enable stayed high through a whole shift

    // tck rests low between frames, so the tap only sees edges in frames
    initial begin
        o_tck = 1'b0;
        o_tms = 1'b1;
        o_tdi = 1'b0;
        last_oe  = 1'b0;
        shift_oe = 1'b0;
    end

    // one tck period: lines set while low, tdo taken just before the rise
    task automatic tick(input logic tms, input logic tdi, output logic tdo);
        o_tms = tms;
        o_tdi = tdi;
        #HALF;
        tdo     = i_tdo;
        last_oe = i_tdo_oe;
        o_tck = 1'b1;
        #HALF;
        o_tck = 1'b0;
    endtask

    // five ones reach the reset state from anywhere, one zero to idle
    task automatic go_idle();
        logic d;
        repeat (5) tick(1'b1, 1'b0, d);
        tick(1'b0, 1'b0, d);
    endtask

    // idle to shift, n bits lsb first, exit, update, idle
    // captured bits come back raw; unconnected ball cells are judged
    // by the caller only where it knows them
    task automatic scan(input logic ir, input int n,
                        input logic [127:0] din, output logic [127:0] dout);
        logic d;
        dout = '0;
        tick(1'b1, 1'b0, d);
        if (ir) begin
            tick(1'b1, 1'b0, d);
        end
        tick(1'b0, 1'b0, d);
        tick(1'b0, 1'b0, d);
        shift_oe = 1'b1;
        for (int i = 0; i < n; i++) begin
            tick(i == n - 1, din[i], dout[i]);
            shift_oe = shift_oe & last_oe;
        end
        // tdi shows the inverse after the frame, so an extra shift shows
        tick(1'b1, ~din[n-1], d);
        tick(1'b0, ~din[n-1], d);
    endtask

    // reserved vendor codes are never loaded from here
    task automatic load_ir(input logic [2:0] code, output logic [2:0] cap);
        logic [127:0] o;
        if (code inside {3'h3, 3'h5, 3'h6}) begin
            code = 3'h7;
        end
        scan(1'b1, 3, {125'h0, code}, o);
        cap = o[2:0];
    endtask

    // capture then straight to update, no shifting
    task automatic update_only();
        logic d;
        tick(1'b1, 1'b0, d);
        tick(1'b0, 1'b0, d);
        tick(1'b1, 1'b0, d);
        tick(1'b1, 1'b0, d);
        tick(1'b0, 1'b0, d);
    endtask
endmodule

/* test/tb.sv */
// self-checking bench for the boundary scan test access port
// assumes the controller model drives the link and the bench the pin side
module tb
    import sbt_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;

    localparam int          DLY    = 5;
    localparam logic [31:0] EXP_ID = {3'h0, 17'h03680, ID_MAKER, 1'h1};
    localparam logic [2:0]  CODES [4] = '{INS_EXTEST, INS_EXTEST,
                                          INS_SAMPLEZ, INS_PRELOAD};

    logic         mclk;
    logic         arst_n;
    logic         tck;
    logic         tms;
    logic         tdi;
    logic         tdo;
    logic         tdo_oe;
    logic [107:0] ball;
    logic         drv_ready;
    logic         ext_mode;
    logic [107:0] ball_drive;
    logic         q_oe;
    logic         upd_stall;
    int           failures;
    int           check_count;

    // pin-side clock, 100 ns
    initial mclk = 1'b0;
    always #50 mclk = ~mclk;

    sbt_tap u_dut (
        .i_mclk(mclk), .i_arst_n(arst_n), .i_tck(tck), .i_tms(tms),
        .i_tdi(tdi), .o_tdo(tdo), .o_tdo_oe(tdo_oe), .i_ball(ball),
        .i_drv_ready(drv_ready), .o_ext_mode(ext_mode),
        .o_ball_drive(ball_drive), .o_q_oe(q_oe), .o_upd_stall(upd_stall)
    );

    sbt_ctl_model u_ctl (
        .o_tck(tck), .o_tms(tms), .o_tdi(tdi), .i_tdo(tdo),
        .i_tdo_oe(tdo_oe)
    );

    // compare and count
    task automatic check(input string what, input logic [127:0] seen,
                         input logic [127:0] exp);
        check_count++;
        if (seen !== exp) begin
            $display("Error %s expected %h seen %h", what, exp, seen);
            failures++;
        end
    endtask

    // verdict and end of run
    task automatic report_and_stop();
        if (failures == 0 && check_count > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    // wait for an applied word on the pin side, bounded
    task automatic settle(input logic [107:0] exp);
        int n;
        n = 0;
        while (ball_drive !== exp && n < 40) begin
            @(posedge mclk);
            n++;
        end
        if (ball_drive !== exp) begin
            failures++;
            report_and_stop();
        end
        repeat (6) @(posedge mclk);
    endtask

    // identification word straight after power-up
    task automatic s_ident();
        logic [127:0] o;
        check("tdo enable idle", tdo_oe, 1'b0);
        u_ctl.scan(1'b0, 32, 128'h0, o);
        check("tdo enable shift", u_ctl.shift_oe, 1'b1);
        check("start bit", o[0], 1'b1);
        check("maker code", o[11:1], ID_MAKER);
        check("revision", o[31:29], 3'h0);
        check("config field", o[28:12], 17'h03680);
        check("density", o[26:24], 3'h3);
        check("width", o[22:21], 2'h3);
        check("gen and port", o[18:17], 2'h0);
        check("latency burst", o[16:15], 2'h0);
        check("io and odt", {o[27], o[14:13]}, 3'h0);
    endtask

    // bypass cell: captured zero, then data one cell late
    task automatic s_bypass();
        logic [127:0] o;
        logic [2:0]   cap;
        u_ctl.load_ir(INS_BYPASS, cap);
        check("ir capture", cap, 3'h1);
        u_ctl.scan(1'b0, 8, 128'ha5, o);
        check("bypass path", o[7:0], 8'h4a);
    endtask

    // reset state brings the identification read back
    task automatic s_reset_default();
        logic [127:0] o;
        u_ctl.go_idle();
        u_ctl.scan(1'b0, 32, 128'h0, o);
        check("id after reset", o[31:0], EXP_ID);
    endtask

    // chain order, internal cell and applied output control per code
    task automatic s_chain();
        logic [127:0] o;
        logic [127:0] din;
        logic [107:0] pat;
        logic [2:0]   cap;
        logic         prev;
        logic         exp_oe;
        prev = 1'b0;
        for (int i = 0; i < 4; i++) begin
            pat = {27{4'(i) ^ 4'h9}};
            din = {19'h0, ~i[0], ~pat};
            @(posedge mclk);
            #DLY ball = pat;
            u_ctl.load_ir(CODES[i], cap);
            u_ctl.scan(1'b0, 109, din, o);
            check("chain balls", o[107:0], pat);
            if (i > 0) begin
                check("internal cell", o[108], prev);
            end
            prev = din[108];
            settle(din[107:0]);
            exp_oe = (CODES[i] == INS_EXTEST) ? din[108] :
                     (CODES[i] == INS_SAMPLEZ) ? 1'b0 : 1'b1;
            check("ext mode", ext_mode, CODES[i] == INS_EXTEST);
            check("bus enable", q_oe, exp_oe);
        end
    endtask

    // fill the hand-over buffer with the pin side stalled, then drain
    task automatic s_fifo();
        int n;
        @(posedge mclk);
        #DLY drv_ready = 1'b0;
        n = 0;
        while (upd_stall !== 1'b1 && n < 40) begin
            u_ctl.update_only();
            repeat (8) @(posedge mclk);
            n++;
        end
        if (upd_stall !== 1'b1) begin
            failures++;
            report_and_stop();
        end
        check("updates before stall", n, UPD_DEPTH + 1);
        @(posedge mclk);
        #DLY drv_ready = 1'b1;
        n = 0;
        while (upd_stall !== 1'b0 && n < 200) begin
            @(posedge mclk);
            n++;
        end
        if (upd_stall !== 1'b0) begin
            failures++;
            report_and_stop();
        end
        repeat (80) @(posedge mclk);
        check("stall cleared", upd_stall, 1'b0);
        check("drained word", ball_drive, ball);
    endtask

    // reset with tck edges, then the scenarios in turn
    initial begin
        failures    = 0;
        check_count = 0;
        arst_n      = 1'b0;
        drv_ready   = 1'b1;
        ball        = '0;
        fork
            u_ctl.go_idle();
            repeat (20) @(posedge mclk);
        join
        @(posedge mclk);
        #DLY arst_n = 1'b1;
        u_ctl.go_idle();
        s_ident();
        s_bypass();
        s_reset_default();
        s_chain();
        s_fifo();
        report_and_stop();
    end
endmodule
